// ==== scrm_pkg.sv ====
// Package: register map constants and types for the serial configuration register bank
// Overview of operation
// - Decode space into chip config 0x00-0x02, index/transfer 0x04-0xFF, program 0x08-0x2D.
// - Registers are eight bits, bit 7 most significant, bit 0 least.
// - Only program writes (0x08-0x2D) go to shadow; 0x00, 0x04, 0x05, 0xFF write through; transfer bit applies shadow.
// - Any reset reloads defaults: port configuration 0x18, grade 0x00.
// - Port configuration bits 5 and 2 request soft reset; device performs it.
// - Address 0x01 returns a fixed read-only part identifier; writes ignored.
package scrm_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned SCRM_AW = 8;
  localparam int unsigned SCRM_DW = 8;
  // ----------------------------------------------------------------
  // Offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SCRM_ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] SCRM_ADDR_PART_ID = 8'h01;
  localparam logic [7:0] SCRM_ADDR_GRADE = 8'h02;
  localparam logic [7:0] SCRM_ADDR_INDEX_2 = 8'h04;
  localparam logic [7:0] SCRM_ADDR_INDEX_1 = 8'h05;
  localparam logic [7:0] SCRM_ADDR_UPDATE = 8'hFF;
  localparam logic [7:0] SCRM_ADDR_PROG_LO = 8'h08;
  localparam logic [7:0] SCRM_ADDR_PROG_HI = 8'h2D;
  localparam logic [7:0] SCRM_ADDR_CFG_HI = 8'h02;
  localparam logic [7:0] SCRM_ADDR_XFER_LO = 8'h04;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SCRM_BIT_LSB_HI = 6;
  localparam int unsigned SCRM_BIT_LSB_LO = 1;
  localparam int unsigned SCRM_BIT_SRST_HI = 5;
  localparam int unsigned SCRM_BIT_SRST_LO = 2;
  localparam int unsigned SCRM_BIT_XFER = 0;
  localparam logic [7:0] SCRM_PORT_CFG_RST = 8'h18;
  localparam logic [7:0] SCRM_PORT_CFG_FIXED = 8'h18; // Bits 4 and 3 read as one
  localparam logic [7:0] SCRM_PORT_CFG_RW = 8'h66;
  localparam logic [7:0] SCRM_GRADE_RST = 8'h00;
  localparam logic [7:0] SCRM_INDEX_RST = 8'h0F;
  localparam logic [7:0] SCRM_INDEX_1_RW = 8'h3F;
  localparam logic [7:0] SCRM_PROG_RST = 8'h00;
  localparam logic [7:0] SCRM_ZERO = 8'h00;
  localparam int unsigned SCRM_PROG_N = 38;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scrm_req_t;
  typedef struct packed {
    logic ack;
    logic hit;
    logic [7:0] rdata;
  } scrm_rsp_t;
  typedef enum logic [2:0] {
    SCRM_RGN_CFG = 3'b001,
    SCRM_RGN_XFER = 3'b010,
    SCRM_RGN_PROG = 3'b100
  } scrm_rgn_t;
endpackage

// ==== scrm_decode.sv ====
// Module: address decoder for the configuration register bank
`timescale 1ns/100ps
module scrm_decode (
  // Address in
  input wire logic [7:0] addr_i,
  // Region flags
  output logic cfg_o,
  output logic xfer_o,
  output logic prog_o,
  output logic buffered_o
);
  import scrm_pkg::*;
  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  // Program region sits inside the index range; it wins there
  assign cfg_o = (addr_i <= SCRM_ADDR_CFG_HI);
  assign prog_o = (addr_i >= SCRM_ADDR_PROG_LO) && (addr_i <= SCRM_ADDR_PROG_HI);
  assign xfer_o = (addr_i >= SCRM_ADDR_XFER_LO) && !prog_o;
  // Unbuffered locations write straight through
  assign buffered_o = !((addr_i == SCRM_ADDR_PORT_CFG) || (addr_i == SCRM_ADDR_INDEX_2) ||
                        (addr_i == SCRM_ADDR_INDEX_1) || (addr_i == SCRM_ADDR_UPDATE));
endmodule

// ==== scrm_regs.sv ====
// Module: configuration register bank with shadow and working copies
`timescale 1ns/100ps
module scrm_regs #(
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary identification value
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Register access from the serial port engine
  input wire scrm_pkg::scrm_req_t req_i,
  output scrm_pkg::scrm_rsp_t rsp_o,
  // Speed grade strap bits (bits 5:4)
  input wire logic [1:0] grade_i,
  // Settings toward the rest of the chip
  output logic lsb_first_o,
  output logic soft_rst_o,
  output logic [7:0] index_2_o,
  output logic [7:0] index_1_o,
  output logic [8*scrm_pkg::SCRM_PROG_N-1:0] prog_o
);
  import scrm_pkg::*;

  logic cfg_hit, xfer_hit, prog_hit, buffered;
  logic [7:0] port_cfg_reg, port_cfg_next;
  logic [7:0] grade_reg;
  logic [7:0] index_2_reg, index_1_reg;
  logic [7:0] shadow_reg [SCRM_PROG_N];
  logic [7:0] work_reg [SCRM_PROG_N];
  logic [7:0] rdata_reg, rdata_next;
  logic ack_reg, hit_reg;
  logic soft_rst_reg;
  logic any_rst, wr_port, wr_upd, do_xfer, srst_req;
  logic [5:0] prog_idx;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  scrm_decode u_decode (
    .addr_i(req_i.addr),
    .cfg_o(cfg_hit),
    .xfer_o(xfer_hit),
    .prog_o(prog_hit),
    .buffered_o(buffered)
  );

  // Index into the program array; only valid when prog_hit
  assign prog_idx = 6'(req_i.addr - SCRM_ADDR_PROG_LO);

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  assign wr_port = req_i.wr && (req_i.addr == SCRM_ADDR_PORT_CFG);
  assign wr_upd = req_i.wr && (req_i.addr == SCRM_ADDR_UPDATE);
  assign do_xfer = wr_upd && req_i.wdata[SCRM_BIT_XFER];
  // Either soft reset bit requests it; host normally sets both
  assign srst_req = wr_port && (req_i.wdata[SCRM_BIT_SRST_HI] ||
                                req_i.wdata[SCRM_BIT_SRST_LO]);
  // Soft reset acts one cycle after the write, like a power-up reset
  assign any_rst = srst_i || soft_rst_reg;

  // Writable bits only; fixed ones and reserved zeros forced
  assign port_cfg_next = (req_i.wdata & SCRM_PORT_CFG_RW) | SCRM_PORT_CFG_FIXED;

  // ----------------------------------------------------------------
  // Soft reset pulse; self clearing so bits read back as zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= srst_req;
    end
  end

  // ----------------------------------------------------------------
  // Unbuffered registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      port_cfg_reg <= SCRM_PORT_CFG_RST;
      index_2_reg <= SCRM_INDEX_RST;
      index_1_reg <= SCRM_INDEX_RST;
      grade_reg <= SCRM_GRADE_RST;
    end else begin
      // Grade picks up the strap after reset release
      grade_reg <= {2'b00, grade_i, 4'h0};
      if (wr_port) begin
        // Soft reset bits never stored: they self clear
        port_cfg_reg <= port_cfg_next & ~((8'h01 << SCRM_BIT_SRST_HI) |
                                           (8'h01 << SCRM_BIT_SRST_LO));
      end
      if (req_i.wr && (req_i.addr == SCRM_ADDR_INDEX_2)) begin
        index_2_reg <= req_i.wdata & SCRM_INDEX_RST;
      end
      if (req_i.wr && (req_i.addr == SCRM_ADDR_INDEX_1)) begin
        index_1_reg <= req_i.wdata & SCRM_INDEX_1_RW;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow stage and working copy of the program region
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      for (int i = 0; i < SCRM_PROG_N; i++) begin
        shadow_reg[i] <= SCRM_PROG_RST;
        work_reg[i] <= SCRM_PROG_RST;
      end
    end else begin
      if (req_i.wr && prog_hit && buffered) begin
        shadow_reg[prog_idx] <= req_i.wdata;
      end
      // Transfer copies what shadow held before this edge
      if (do_xfer) begin
        for (int i = 0; i < SCRM_PROG_N; i++) begin
          work_reg[i] <= shadow_reg[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux; program reads show shadow so writes read back at once
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = SCRM_ZERO;
    case (req_i.addr)
      SCRM_ADDR_PORT_CFG: rdata_next = port_cfg_reg;
      SCRM_ADDR_PART_ID: rdata_next = PART_ID;
      SCRM_ADDR_GRADE: rdata_next = grade_reg;
      SCRM_ADDR_INDEX_2: rdata_next = index_2_reg;
      SCRM_ADDR_INDEX_1: rdata_next = index_1_reg;
      SCRM_ADDR_UPDATE: rdata_next = SCRM_ZERO; // Transfer bit self clears
      default: begin
        if (prog_hit) begin
          rdata_next = shadow_reg[prog_idx];
        end
      end
    endcase
  end

  // Response registered one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_reg <= SCRM_ZERO;
      ack_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= req_i.rd ? rdata_next : rdata_reg;
      ack_reg <= req_i.rd || req_i.wr;
      hit_reg <= cfg_hit || xfer_hit || prog_hit;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_o = '{ack: ack_reg, hit: hit_reg, rdata: rdata_reg};
  assign lsb_first_o = port_cfg_reg[SCRM_BIT_LSB_HI] || port_cfg_reg[SCRM_BIT_LSB_LO];
  assign soft_rst_o = soft_rst_reg;
  assign index_2_o = index_2_reg;
  assign index_1_o = index_1_reg;
  for (genvar g = 0; g < SCRM_PROG_N; g++) begin : g_prog
    assign prog_o[8*g +: 8] = work_reg[g];
  end
endmodule

// ==== scrm_asserts.sv ====
// Checker: port-level assertions for the configuration register bank
`timescale 1ns/100ps
module scrm_asserts #(
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary identification value
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Bank ports
  input wire scrm_pkg::scrm_req_t req_i,
  input wire scrm_pkg::scrm_rsp_t rsp_o,
  input wire logic [1:0] grade_i,
  input wire logic lsb_first_o,
  input wire logic soft_rst_o,
  input wire logic [7:0] index_2_o,
  input wire logic [7:0] index_1_o,
  input wire logic [8*scrm_pkg::SCRM_PROG_N-1:0] prog_o
);
  import scrm_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Request qualifiers
  wire logic req_any = req_i.wr | req_i.rd;
  wire logic rd_cfg = req_i.rd && req_i.addr == 8'h00;
  wire logic xfer = req_i.wr && req_i.addr == 8'hFF && req_i.wdata[0];
  chk_ack_timing: assert property (req_any |=> rsp_o.ack) else $error("ack missing");
  chk_stray_ack: assert property (!req_any |=> !rsp_o.ack) else $error("stray ack");
  chk_gap_miss: assert property (
    req_i.rd && req_i.addr == 8'h03 |=> !rsp_o.hit && rsp_o.rdata == 8'h00)
    else $error("gap address answered");
  chk_part_id: assert property (
    req_i.rd && req_i.addr == 8'h01 |=> rsp_o.rdata == PART_ID) else $error("bad part id");
  chk_cfg_fixed: assert property (
    rd_cfg |=> rsp_o.rdata[4:3] == 2'b11 && (rsp_o.rdata & 8'hA5) == 8'h00)
    else $error("port config fixed bits wrong");
  chk_lsb_track: assert property (
    rd_cfg |=> lsb_first_o == (rsp_o.rdata[6] | rsp_o.rdata[1])) else $error("lsb mismatch");
  chk_soft_pulse: assert property (
    req_i.wr && req_i.addr == 8'h00 && (req_i.wdata[5] || req_i.wdata[2])
    |=> soft_rst_o ##1 !soft_rst_o) else $error("soft reset pulse wrong");
  chk_shadow_hold: assert property (
    !$past(srst_i) && !soft_rst_o && !$past(soft_rst_o) && !$past(xfer) |-> $stable(prog_o))
    else $error("working copy moved without transfer");
  chk_index_dflt: assert property (
    $past(srst_i) |-> index_2_o == SCRM_INDEX_RST && index_1_o == SCRM_INDEX_RST)
    else $error("index default wrong");
endmodule

// ==== scrm_host.sv ====
// Partner: serial host model that shapes register requests
`timescale 1ns/100ps
module scrm_host (
  // Command from the sequence
  input wire scrm_pkg::scrm_req_t cmd_i,
  // Request toward the bank
  output scrm_pkg::scrm_req_t req_o
);
  import scrm_pkg::*;
  // Mirrored nibbles so either shift order reads the same setting
  wire logic cfg_wr = cmd_i.wr && cmd_i.addr == SCRM_ADDR_PORT_CFG;
  wire logic gap_wr = cmd_i.wr && cmd_i.addr == 8'h03;
  wire logic lsb_sel = cmd_i.wdata[6] | cmd_i.wdata[1];
  wire logic rst_sel = cmd_i.wdata[5] | cmd_i.wdata[2];
  wire logic [7:0] cfg_data = {1'b0, lsb_sel, rst_sel, 2'b11, rst_sel, lsb_sel, 1'b0};
  wire logic [7:0] wdata = cfg_wr ? cfg_data : (gap_wr ? SCRM_ZERO : cmd_i.wdata);
  assign req_o = '{wr: cmd_i.wr, rd: cmd_i.rd, addr: cmd_i.addr, wdata: wdata};
endmodule

// ==== scrm_tb.sv ====
// Testbench: register bank access sequences with expected values
`timescale 1ns/100ps
module tb;
  import scrm_pkg::*;
  localparam logic [7:0] PART_ID = 8'h3C; // Arbitrary identification value
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  scrm_req_t cmd = '0;
  scrm_req_t req;
  scrm_rsp_t rsp;
  logic lsb_first, soft_rst, h;
  logic [7:0] idx2, idx1, q;
  logic [8*SCRM_PROG_N-1:0] prog;
  logic [7:0] pg [2] = '{8'h00, 8'h25};
  int err_total = 0;
  int checked = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  scrm_host host (.cmd_i(cmd), .req_o(req));
  scrm_regs #(.PART_ID(PART_ID)) dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req),
    .rsp_o(rsp), .grade_i(2'b10), .lsb_first_o(lsb_first), .soft_rst_o(soft_rst),
    .index_2_o(idx2), .index_1_o(idx1), .prog_o(prog));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access: request for one cycle, answer read one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    cmd = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk_i);
    cmd = '0;
    chk("ack", {7'h00, rsp.ack}, 8'h01);
    q = rsp.rdata;
    h = rsp.hit;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hexp);
    acc(1'b0, a, 8'h00);
    chk("rdata", q, exp);
    chk("hit", {7'h00, h}, {7'h00, hexp});
  endtask
  task automatic do_reset();
    srst_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    srst_i = 1'b0;
  endtask
  // Shadow write must not reach the working copy before the transfer bit
  task automatic prog_pass();
    foreach (pg[i]) begin
      acc(1'b1, SCRM_ADDR_PROG_LO + pg[i], 8'hC3 ^ pg[i]);
      chk("working", prog[8*pg[i]+:8], 8'h00);
      rd_chk(SCRM_ADDR_PROG_LO + pg[i], 8'hC3 ^ pg[i], 1'b1);
      // Update write with the transfer bit clear must leave the working copy alone
      acc(1'b1, SCRM_ADDR_UPDATE, 8'h00);
      chk("working", prog[8*pg[i]+:8], 8'h00);
      acc(1'b1, SCRM_ADDR_UPDATE, 8'h01);
      chk("working", prog[8*pg[i]+:8], 8'hC3 ^ pg[i]);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    rd_chk(SCRM_ADDR_PORT_CFG, SCRM_PORT_CFG_RST, 1'b1);
    rd_chk(SCRM_ADDR_GRADE, 8'h20, 1'b1);
    rd_chk(8'h03, 8'h00, 1'b0);
    acc(1'b1, SCRM_ADDR_PART_ID, 8'h00);
    rd_chk(SCRM_ADDR_PART_ID, PART_ID, 1'b1);
    acc(1'b1, SCRM_ADDR_GRADE, 8'hFF);
    rd_chk(SCRM_ADDR_GRADE, 8'h20, 1'b1);
    prog_pass();
    acc(1'b1, SCRM_ADDR_PORT_CFG, 8'h02);
    rd_chk(SCRM_ADDR_PORT_CFG, 8'h5A, 1'b1);
    chk("lsb", {7'h00, lsb_first}, 8'h01);
    acc(1'b1, SCRM_ADDR_INDEX_2, 8'h0A);
    chk("index2", idx2, 8'h0A);
    acc(1'b1, SCRM_ADDR_INDEX_1, 8'hFF);
    chk("index1", idx1, SCRM_INDEX_1_RW);
    acc(1'b1, SCRM_ADDR_PORT_CFG, 8'h24);
    chk("soft", {7'h00, soft_rst}, 8'h01);
    repeat (2) @(negedge ref_clk_i);
    chk("index2", idx2, SCRM_INDEX_RST);
    chk("working", prog[8*37+:8], 8'h00);
    rd_chk(SCRM_ADDR_PORT_CFG, SCRM_PORT_CFG_RST, 1'b1);
    prog_pass();
    do_reset();
    chk("working", prog[8*37+:8], 8'h00);
    chk("index1", idx1, SCRM_INDEX_RST);
    report_and_stop();
  end
  // Watchdog: the sequence needs about 1.4 us, allow far more
  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end
endmodule
bind scrm_regs scrm_asserts #(.PART_ID(PART_ID)) chk_i (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .req_i(req_i), .rsp_o(rsp_o), .grade_i(grade_i),
  .lsb_first_o(lsb_first_o), .soft_rst_o(soft_rst_o), .index_2_o(index_2_o),
  .index_1_o(index_1_o), .prog_o(prog_o));
